// File: hdl/tsp_channel.sv
`timescale 1ns/1ps
module tsp_channel #(
    parameter logic [6:0] WORK_BASE = tsp_pkg::CMD_WORK0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             measuring,
    input  wire logic             enable,
    input  wire logic             level,
    input  wire logic             drift_en,
    input  wire logic             teach,
    input  wire logic             enter_normal,
    input  wire tsp_pkg::tsp_wr_t wr,
    output logic [tsp_pkg::W-1:0] measured,
    output logic                  touched,
    output tsp_pkg::tsp_par_t     work,
    output tsp_pkg::tsp_par_t     live
);
    import tsp_pkg::*;

    logic         level_d;
    logic [W-1:0] cnt;
    logic         new_measure_request_pin;
    logic signed [W:0] diff;
    logic signed [W:0] release_lvl;

    // discharge period counter, latched at the end of each discharge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            level_d  <= 1'b0;
            cnt      <= '0;
            measured <= '0;
            new_measure_request_pin <= 1'b0;
        end
        else
        begin
            new_measure_request_pin <= 1'b0;
            level_d  <= level;
            if (!measuring || !enable)
                cnt <= '0;
            else if (level_d && !level)
            begin
                measured <= cnt;
                cnt      <= '0;
                new_measure_request_pin <= 1'b1;
            end
            else if (level && tick && cnt != {W{1'b1}})
                cnt <= cnt + 16'h0001;
        end
    end

    // shorter discharge means touch, so the distance is reference minus measured
    assign diff        = $signed({1'b0, live.ref_val}) - $signed({1'b0, measured});
    assign release_lvl = $signed({1'b0, live.thr}) - $signed({1'b0, live.hys});

    // touch judgement with hysteresis on release
    always_ff @(posedge mclk)
    begin
        if (rst || !enable)
            touched <= 1'b0;
        else if (new_measure_request_pin)
        begin
            if (!touched && diff > $signed({1'b0, live.thr}))
                touched <= 1'b1;
            else if (touched && diff <= release_lvl)
                touched <= 1'b0;
        end
    end

    // working set, live set and drift tracking
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            work <= '{ref_val: REF_RST, thr: THR_RST, hys: HYS_RST};
            live <= '{ref_val: REF_RST, thr: THR_RST, hys: HYS_RST};
        end
        else
        begin
            if (wr.en && wr.addr == WORK_BASE)
                work.ref_val <= wr.data;
            else if (teach && new_measure_request_pin)
                work.ref_val <= measured;
            if (wr.en && wr.addr == WORK_BASE + 7'h01)
                work.thr <= wr.data;
            if (wr.en && wr.addr == WORK_BASE + 7'h02)
                work.hys <= wr.data;
            if (enter_normal)
                live <= work;
            else if (drift_en && new_measure_request_pin && !touched && measured != live.ref_val)
            begin
                if (measured > live.ref_val)
                    live.ref_val <= live.ref_val + 16'h0001;
                else
                    live.ref_val <= live.ref_val - 16'h0001;
            end
        end
    end
endmodule

// File: hdl/tsp_pkg.sv
package tsp_pkg;
    // channel and word sizes
    localparam int NCH        = 8;
    localparam int W          = 16;
    localparam int CODE_W     = 7;
    localparam int FRAME_BITS = 32;
    // bit counts that close the command, dummy and data bytes
    localparam logic [5:0] CMD_LAST_BIT   = 6'h07;
    localparam logic [5:0] DUMMY_LAST_BIT = 6'h0f;
    localparam logic [5:0] DATA_LAST_BIT  = 6'h1f;
    // command codes
    localparam logic [6:0] CMD_ID       = 7'h00;
    localparam logic [6:0] CMD_TOUCH    = 7'h01;
    localparam logic [6:0] CMD_MEAS0    = 7'h02;
    localparam logic [6:0] CMD_LIVE0    = 7'h0e;
    localparam logic [6:0] CMD_RO_LAST  = 7'h25;
    localparam logic [6:0] CMD_RW_FIRST = 7'h39;
    localparam logic [6:0] CMD_CHANNEL_ENABLE_PARAM     = 7'h39;
    localparam logic [6:0] CMD_CFG      = 7'h3a;
    localparam logic [6:0] CMD_STORE    = 7'h3f;
    localparam logic [6:0] CMD_WORK0    = 7'h50;
    localparam logic [6:0] CMD_RW_LAST  = 7'h67;
    localparam int         PAR_STRIDE   = 3;
    // configuration word fields
    localparam int CFG_DRIFT_BIT = 0;
    localparam int CFG_POL_BIT   = 1;
    // reset values, used until the stored image has been loaded
    localparam logic [15:0] CHANNEL_ENABLE_PARAM_RST = 16'h00ff;
    localparam logic [15:0] CFG_RST  = 16'h0001;
    localparam logic [15:0] REF_RST  = 16'h0100;
    localparam logic [15:0] THR_RST  = 16'h0020;
    localparam logic [15:0] HYS_RST  = 16'h0008;
    // identity word, value arbitrary
    localparam logic [15:0] ID_VALUE = 16'h5a3c;
    // measurement tick divider (mclk cycles per count)
    localparam int MEASURE_REQUEST_PIN_DIV = 4;

    typedef enum logic [1:0] {
        MODE_SETUP   = 2'b00,
        MODE_TEACH   = 2'b01,
        MODE_NORMAL  = 2'b11,
        MODE_STANDBY = 2'b10
    } tsp_mode_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_HEAD = 2'b01,
        SER_DATA = 2'b11,
        SER_DONE = 2'b10
    } tsp_ser_t;

    typedef enum logic [1:0] {
        NV_IDLE  = 2'b00,
        NV_LOAD  = 2'b01,
        NV_STORE = 2'b11
    } tsp_nv_t;

    typedef struct packed {
        logic             en;
        logic [CODE_W-1:0] addr;
        logic [W-1:0]     data;
    } tsp_wr_t;

    typedef struct packed {
        logic [W-1:0] ref_val;
        logic [W-1:0] thr;
        logic [W-1:0] hys;
    } tsp_par_t;
endpackage

// File: hdl/tsp_top.sv
// Operation
// - mode comes from config-select and measure-request pins per the four-way table
// - on/off variant drives each channel's judgement on its own output pin in normal mode
// - serial variant serves results over chip select, clock and one data line
// - each channel counts its discharge period as its measured value
// - touch when drop exceeds judging change; release only past hysteresis
// - every channel keeps its own reference, judging change and hysteresis
// - drift compensation tracks the untouched value; switchable only in setup
// - device is a slave only; host drives chip select and clock
// - clock idles high; data sampled on rising edge
// - bytes go most significant bit first both ways
// - a frame is command, dummy, then two data bytes
// - command byte top bit is the write flag, rest selects the code
// - measurement pauses during a frame in normal mode
// - measurement resumes by itself once the frame ends
// - chip select released early throws away the whole frame
// - writes to read-only codes are ignored
// - low codes readable always; parameter codes only in setup mode
// - writes hit working registers; channel sets used on entering normal, global ones at once; reload at reset
// - store command copies working registers to non-volatile storage
// - measure-request high starts measuring; low stops it, in standby with config-select high, in setup with it low
// - low on the reset pin resets the whole device
// - each output can show touch active low or active high
`timescale 1ns/1ps
module tsp_top #(
    parameter logic [15:0] CHIP_ID = tsp_pkg::ID_VALUE
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   chip_reset_n,
    input  wire logic                   config_select_pin,
    input  wire logic                   measure_request_pin,
    input  wire logic                   serial_output_select,
    input  wire logic [tsp_pkg::NCH-1:0] discharge_level,
    output logic                        measure_enable,
    output logic [tsp_pkg::NCH-1:0]     channel_touch_output,
    input  wire logic                   serial_chip_select_n,
    input  wire logic                   serial_clock,
    input  wire logic                   serial_bidir_data_in,
    output logic                        serial_bidir_data_out,
    output logic                        serial_bidir_data_oe,
    output logic                        nvm_rd,
    output logic                        nvm_wr,
    output logic [tsp_pkg::CODE_W-1:0]  nvm_addr,
    output logic [tsp_pkg::W-1:0]       nvm_wdata,
    input  wire logic [tsp_pkg::W-1:0]  nvm_rdata
);
    import tsp_pkg::*;

    logic [1:0]       rstn_sync;
    logic             sys_rst;
    logic [1:0]       cfg_sync;
    logic [1:0]       measure_request_pin_sync;
    logic [NCH-1:0]   lvl_s1;
    logic [NCH-1:0]   lvl_s2;
    logic [2:0]       sclk_sync;
    logic [1:0]       cs_sync;
    logic [1:0]       sd_sync;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             cs_active;
    tsp_mode_t        mode;
    tsp_mode_t        mode_q;
    logic             enter_normal;
    logic             measuring;
    logic [$clog2(MEASURE_REQUEST_PIN_DIV)-1:0] div_cnt;
    logic             tick;
    tsp_ser_t         ser_state;
    logic [5:0]       bit_cnt;
    logic [W-1:0]     shift_in;
    logic [7:0]       cmd;
    logic [W-1:0]     shift_out;
    logic             commit;
    logic [W-1:0]     commit_data;
    logic             wr_ok;
    tsp_nv_t          nv_state;
    logic [CODE_W-1:0] nv_ptr;
    logic             load_wr;
    logic [W-1:0]     channel_enable_param;
    logic [W-1:0]     cfg;
    tsp_wr_t          wr;
    logic [CODE_W-1:0] rd_addr;
    logic [W-1:0]     rd_data;
    logic             rd_ok;
    logic [W-1:0]     measured [NCH];
    logic [NCH-1:0]   touched;
    tsp_par_t         work [NCH];
    tsp_par_t         live [NCH];

    // pin synchronisers; logic reads the second stage, and the serial clock edge detect also reads its third stage
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rstn_sync <= 2'h0;
            cfg_sync  <= 2'h3;
            measure_request_pin_sync <= 2'h0;
            lvl_s1    <= '0;
            lvl_s2    <= '0;
            sclk_sync <= 3'h7;
            cs_sync   <= 2'h3;
            sd_sync   <= 2'h0;
        end
        else
        begin
            rstn_sync <= {rstn_sync[0], chip_reset_n};
            cfg_sync  <= {cfg_sync[0], config_select_pin};
            measure_request_pin_sync <= {measure_request_pin_sync[0], measure_request_pin};
            lvl_s1    <= discharge_level;
            lvl_s2    <= lvl_s1;
            sclk_sync <= {sclk_sync[1:0], serial_clock};
            cs_sync   <= {cs_sync[0], serial_chip_select_n};
            sd_sync   <= {sd_sync[0], serial_bidir_data_in};
        end
    end

    assign sys_rst   = rst || !rstn_sync[1];
    assign sclk_rise = sclk_sync[1] && !sclk_sync[2];
    assign sclk_fall = !sclk_sync[1] && sclk_sync[2];
    assign cs_active = !cs_sync[1];

    // operating mode from the two mode pins
    always_comb
    begin
        case ({cfg_sync[1], measure_request_pin_sync[1]})
            2'b11:   mode = MODE_NORMAL;
            2'b10:   mode = MODE_STANDBY;
            2'b01:   mode = MODE_TEACH;
            default: mode = MODE_SETUP;
        endcase
    end

    // remember the mode to spot entry into normal measurement
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            mode_q <= MODE_SETUP;
        else
            mode_q <= mode;
    end

    assign enter_normal = mode == MODE_NORMAL && mode_q != MODE_NORMAL;
    // paused while a frame or storage walk is in progress
    assign measuring = (mode == MODE_NORMAL || mode == MODE_TEACH)
                       && ser_state == SER_IDLE && nv_state == NV_IDLE;

    // count-rate enable for the discharge counters
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !measuring)
            div_cnt <= '0;
        else if (div_cnt == ($clog2(MEASURE_REQUEST_PIN_DIV))'(MEASURE_REQUEST_PIN_DIV - 1))
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    assign tick = measuring && div_cnt == '0;

    // serial frame receiver and transmitter
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !cs_active)
        begin
            ser_state            <= SER_IDLE;
            bit_cnt              <= '0;
            shift_in             <= '0;
            cmd                  <= '0;
            shift_out            <= '0;
            serial_bidir_data_oe <= 1'b0;
            commit               <= 1'b0;
        end
        else
        begin
            commit <= 1'b0;
            case (ser_state)
                SER_IDLE: ser_state <= SER_HEAD;
                SER_HEAD, SER_DATA:
                begin
                    if (sclk_rise)
                    begin
                        shift_in <= {shift_in[W-2:0], sd_sync[1]};
                        bit_cnt  <= bit_cnt + 6'h01;
                        if (bit_cnt == CMD_LAST_BIT)
                            cmd <= {shift_in[6:0], sd_sync[1]};
                        if (bit_cnt == DUMMY_LAST_BIT)
                        begin
                            ser_state            <= SER_DATA;
                            shift_out            <= rd_ok ? rd_data : '0;
                            serial_bidir_data_oe <= !cmd[7];
                        end
                        if (bit_cnt == DATA_LAST_BIT)
                        begin
                            ser_state            <= SER_DONE;
                            serial_bidir_data_oe <= 1'b0;
                            commit               <= cmd[7];
                        end
                    end
                    if (sclk_fall && ser_state == SER_DATA && bit_cnt != DUMMY_LAST_BIT + 6'h01)
                        shift_out <= {shift_out[W-2:0], 1'b0};
                end
                SER_DONE: ser_state <= SER_DONE;
                default:  ser_state <= SER_IDLE;
            endcase
        end
    end

    assign serial_bidir_data_out = shift_out[W-1];
    assign commit_data = shift_in;

    // writes count only in setup, to parameter codes, with storage idle
    assign wr_ok = commit && mode == MODE_SETUP && nv_state == NV_IDLE
                   && cmd[6:0] >= CMD_RW_FIRST && cmd[6:0] <= CMD_RW_LAST;

    // one write port shared by the serial side and the startup reload
    always_comb
    begin
        wr = '{en: 1'b0, addr: cmd[6:0], data: commit_data};
        if (load_wr)
            wr = '{en: 1'b1, addr: nv_ptr, data: nvm_rdata};
        else if (wr_ok && cmd[6:0] != CMD_STORE)
            wr.en = 1'b1;
    end

    // global working registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            channel_enable_param <= CHANNEL_ENABLE_PARAM_RST;
            cfg  <= CFG_RST;
        end
        else if (wr.en && wr.addr == CMD_CHANNEL_ENABLE_PARAM)
            channel_enable_param <= wr.data;
        else if (wr.en && wr.addr == CMD_CFG)
            cfg <= wr.data;
    end

    // reload after reset, copy out on the store command
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            nv_state  <= NV_LOAD;
            nv_ptr    <= CMD_RW_FIRST;
            nvm_rd    <= 1'b0;
            nvm_wr    <= 1'b0;
            nvm_addr  <= '0;
            nvm_wdata <= '0;
            load_wr   <= 1'b0;
        end
        else
        begin
            nvm_wr  <= 1'b0;
            load_wr <= nvm_rd;
            nvm_rd  <= 1'b0;
            case (nv_state)
                NV_IDLE:
                begin
                    nv_ptr <= CMD_RW_FIRST;
                    if (wr_ok && cmd[6:0] == CMD_STORE)
                        nv_state <= NV_STORE;
                end
                NV_LOAD:
                begin
                    nvm_addr <= nv_ptr;
                    nvm_rd   <= !nvm_rd && !load_wr;
                    if (load_wr)
                    begin
                        nv_ptr <= nv_ptr + 7'h01;
                        if (nv_ptr == CMD_RW_LAST)
                            nv_state <= NV_IDLE;
                    end
                end
                NV_STORE:
                begin
                    nvm_wr    <= 1'b1;
                    nvm_addr  <= nv_ptr;
                    nvm_wdata <= rd_data;
                    nv_ptr    <= nv_ptr + 7'h01;
                    if (nv_ptr == CMD_RW_LAST)
                        nv_state <= NV_IDLE;
                end
                default: nv_state <= NV_IDLE;
            endcase
        end
    end

    // read map shared by the serial side and the store walk
    assign rd_addr = nv_state == NV_STORE ? nv_ptr : cmd[6:0];
    assign rd_ok   = rd_addr <= CMD_RO_LAST
                     || (mode == MODE_SETUP && rd_addr >= CMD_RW_FIRST && rd_addr <= CMD_RW_LAST);

    always_comb
    begin
        rd_data = '0;
        if (rd_addr == CMD_ID)
            rd_data = CHIP_ID;
        else if (rd_addr == CMD_TOUCH)
            rd_data = {{(W-NCH){1'b0}}, touched};
        else if (rd_addr == CMD_CHANNEL_ENABLE_PARAM)
            rd_data = channel_enable_param;
        else if (rd_addr == CMD_CFG)
            rd_data = cfg;
        for (int i = 0; i < NCH; i++)
        begin
            if (rd_addr == CMD_MEAS0 + 7'(i))
                rd_data = measured[i];
            if (rd_addr == CMD_LIVE0 + 7'(PAR_STRIDE * i))
                rd_data = live[i].ref_val;
            if (rd_addr == CMD_LIVE0 + 7'(PAR_STRIDE * i + 1))
                rd_data = live[i].thr;
            if (rd_addr == CMD_LIVE0 + 7'(PAR_STRIDE * i + 2))
                rd_data = live[i].hys;
            if (rd_addr == CMD_WORK0 + 7'(PAR_STRIDE * i))
                rd_data = work[i].ref_val;
            if (rd_addr == CMD_WORK0 + 7'(PAR_STRIDE * i + 1))
                rd_data = work[i].thr;
            if (rd_addr == CMD_WORK0 + 7'(PAR_STRIDE * i + 2))
                rd_data = work[i].hys;
        end
    end

    // one judge per channel
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        tsp_channel #(
            .WORK_BASE (CMD_WORK0 + 7'(PAR_STRIDE * g))
        ) u_ch (
            .mclk         (mclk),
            .rst          (sys_rst),
            .tick         (tick),
            .measuring    (measuring),
            .enable       (channel_enable_param[g]),
            .level        (lvl_s2[g]),
            .drift_en     (cfg[CFG_DRIFT_BIT]),
            .teach        (mode == MODE_TEACH),
            .enter_normal (enter_normal),
            .wr           (wr),
            .measured     (measured[g]),
            .touched      (touched[g]),
            .work         (work[g]),
            .live         (live[g])
        );
    end

    // measurement request to the analog front end
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            measure_enable <= 1'b0;
        else
            measure_enable <= measuring;
    end

    // per-channel touch outputs with selectable polarity
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            channel_touch_output <= {NCH{~CFG_RST[CFG_POL_BIT]}};
        else if (mode == MODE_NORMAL && !serial_output_select)
            channel_touch_output <= {NCH{~cfg[CFG_POL_BIT]}} ^ touched;
        else
            channel_touch_output <= {NCH{~cfg[CFG_POL_BIT]}};
    end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    import tsp_pkg::*;
    localparam logic [15:0] TB_ID = 16'h1357; // arbitrary identity value
    logic mclk = 1'b0, rst = 1'b1, pin_rst_n = 1'b1, cfg_pin = 1'b0, req_pin = 1'b0, ser_sel = 1'b1;
    logic [NCH-1:0] dis = '0, touch_out;
    logic measure_request_pin_en, sd_out, sd_oe, cs_n, sclk, sd_line, nvm_rd, nvm_wr;
    logic [CODE_W-1:0] nvm_addr;
    logic [W-1:0] nvm_wdata, rd, nvm_rdata = '0;
    logic [W-1:0] nvm [0:127];
    logic [W-1:0] shadow [0:127];
    int error_cnt = 0, checks_done = 0, wr_cnt = 0;
    always #2.5 mclk = ~mclk;
    tsp_top #(.CHIP_ID(TB_ID)) DUT (.mclk(mclk), .rst(rst), .chip_reset_n(pin_rst_n),
        .config_select_pin(cfg_pin), .measure_request_pin(req_pin), .serial_output_select(ser_sel),
        .discharge_level(dis), .measure_enable(measure_request_pin_en), .channel_touch_output(touch_out),
        .serial_chip_select_n(cs_n), .serial_clock(sclk), .serial_bidir_data_in(sd_line),
        .serial_bidir_data_out(sd_out), .serial_bidir_data_oe(sd_oe), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
        .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
    tsp_host host (.mclk(mclk), .dev_out(sd_out), .dev_oe(sd_oe), .cs_n(cs_n), .sclk(sclk), .line(sd_line));
    // storage array, random comparator levels
    always @(posedge mclk)
    begin
        if (nvm_wr)
            nvm[nvm_addr] <= nvm_wdata;
        nvm_rdata <= nvm_rd ? nvm[nvm_addr] : ~nvm_rdata;
        wr_cnt <= wr_cnt + int'(nvm_wr);
        dis <= NCH'($urandom);
    end
    function automatic logic [15:0] exp_rd(input logic [6:0] c, input logic s);
        return (c == CMD_ID) ? TB_ID : (c >= CMD_WORK0 && s) ? shadow[c] : 16'h0000;
    endfunction
    task automatic mode(input logic c, input logic m);
        @(posedge mclk) cfg_pin <= c;
        req_pin <= m;
        repeat (10) @(posedge mclk);
    endtask
    task automatic rdchk(input logic [6:0] c, input logic s);
        host.xfer({1'b0, c}, 16'h0000, 32, rd);
        `CHK("read", exp_rd(c, s), rd)
    endtask
    // writes that land update the shadow of the working set
    task automatic wr(input logic [6:0] c, input logic [15:0] v, input int nb);
        host.xfer({1'b1, c}, v, nb, rd);
        if (nb == 32 && !cfg_pin && !req_pin && c >= CMD_WORK0)
            shadow[c] = v;
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        logic [6:0] a;
        int w0;
        void'($urandom(94416));
        for (int i = 0; i < 128; i++)
        begin
            nvm[i] = W'($urandom);
            shadow[i] = nvm[i];
        end
        nvm[CMD_CFG] = 16'h0000;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (200) @(posedge mclk);
        for (a = CMD_WORK0; a <= CMD_RW_LAST; a++)
            rdchk(a, 1'b1);
        rdchk(CMD_ID, 1'b1);
        rdchk(7'h26, 1'b1);
        repeat (8)
        begin
            a = CMD_WORK0 + 7'($urandom_range(23));
            wr(a, W'($urandom), 32);
            rdchk(a, 1'b1);
        end
        wr(CMD_ID, W'($urandom), 32);
        rdchk(CMD_ID, 1'b1);
        wr(CMD_WORK0, ~shadow[CMD_WORK0], 20);
        rdchk(CMD_WORK0, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            mode(k[1], k[0]);
            `CHK("measure_request_pin_en", k[0], measure_request_pin_en)
            `CHK("touch_out", 8'hff, touch_out)
            wr(CMD_WORK0 + 7'h01, W'($urandom), 32);
            rdchk(CMD_WORK0 + 7'h01, k == 0);
            rdchk(CMD_ID, 1'b1);
        end
        mode(1'b0, 1'b0);
        rdchk(CMD_WORK0 + 7'h01, 1'b1);
        w0 = wr_cnt;
        wr(CMD_STORE, 16'h0000, 32);
        repeat (100) @(posedge mclk);
        `CHK("store_count", 47, wr_cnt - w0)
        `CHK("stored", shadow[CMD_WORK0 + 7'h01], nvm[CMD_WORK0 + 7'h01])
        wr(CMD_WORK0 + 7'h01, W'($urandom), 32);
        shadow[CMD_WORK0 + 7'h01] = nvm[CMD_WORK0 + 7'h01];
        pin_rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        pin_rst_n <= 1'b1;
        repeat (200) @(posedge mclk);
        rdchk(CMD_WORK0 + 7'h01, 1'b1);
        // on/off outputs, active high, only channel 0 enabled with a wide reference margin
        wr(CMD_CHANNEL_ENABLE_PARAM, 16'h0001, 32);
        wr(CMD_CFG, 16'h0002, 32);
        wr(CMD_WORK0, 16'h0100, 32);
        wr(CMD_WORK0 + 7'h01, 16'h0010, 32);
        wr(CMD_WORK0 + 7'h02, 16'h0008, 32);
        `CHK("touch_idle", 8'h00, touch_out)
        ser_sel <= 1'b0;
        mode(1'b1, 1'b1);
        repeat (100) @(posedge mclk);
        `CHK("touch_out", 8'h01, touch_out)
        host.xfer({1'b0, CMD_TOUCH}, 16'h0000, 32, rd);
        `CHK("touch_bits", 16'h0001, rd)
        host.xfer({1'b0, CMD_LIVE0 + 7'h01}, 16'h0000, 32, rd);
        `CHK("live_thr", 16'h0010, rd)
        report_and_stop();
    end
endmodule

// File: sim/tsp_assertions.sv
`timescale 1ns/1ps
module tsp_chk (
    input wire logic                       mclk,
    input wire logic                       rst,
    input wire logic                       config_select_pin,
    input wire logic                       measure_request_pin,
    input wire logic                       serial_chip_select_n,
    input wire logic                       measure_enable,
    input wire logic                       serial_bidir_data_oe,
    input wire logic                       nvm_rd,
    input wire logic                       nvm_wr,
    input wire logic [tsp_pkg::CODE_W-1:0] nvm_addr
);
    import tsp_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // chip select held idle or held in a frame
    sequence cs_idle;
        serial_chip_select_n [*5];
    endsequence
    sequence cs_busy;
        !serial_chip_select_n [*6];
    endsequence
    a_oe_when_idle: assert property (cs_idle |-> !serial_bidir_data_oe)
        else $error("data line driven outside a frame");
    a_oe_rise_frame: assert property ($rose(serial_bidir_data_oe) |-> !serial_chip_select_n)
        else $error("data driver enabled without chip select");
    a_measure_request_pin_pause: assert property (cs_busy |-> !measure_enable)
        else $error("measuring during a frame");
    a_measure_request_pin_setup: assert property ((!config_select_pin && !measure_request_pin) [*6] |-> !measure_enable)
        else $error("measuring in setup mode");
    a_measure_request_pin_standby: assert property ((config_select_pin && !measure_request_pin) [*6] |-> !measure_enable)
        else $error("measuring in standby");
    a_measure_request_pin_needs_req: assert property ($rose(measure_enable) |-> $past(measure_request_pin, 3))
        else $error("measuring without a request");
    a_nvm_rd_walk: assert property (nvm_rd |=> !nvm_rd ##1 !nvm_rd)
        else $error("reload read spacing wrong");
    a_nvm_excl: assert property (!(nvm_rd && nvm_wr))
        else $error("storage read and write together");
    a_store_start: assert property ($rose(nvm_wr) |-> nvm_addr == CMD_RW_FIRST)
        else $error("store walk starts at wrong code");
    a_store_step: assert property (nvm_wr && $past(nvm_wr) |-> nvm_addr == $past(nvm_addr) + 7'h01)
        else $error("store walk skips a code");
    a_store_end: assert property ($fell(nvm_wr) |-> $past(nvm_addr) == CMD_RW_LAST)
        else $error("store walk ends at wrong code");
endmodule
bind tsp_top tsp_chk u_chk (
    .mclk                 (mclk),
    .rst                  (rst),
    .config_select_pin    (config_select_pin),
    .measure_request_pin  (measure_request_pin),
    .serial_chip_select_n (serial_chip_select_n),
    .measure_enable       (measure_enable),
    .serial_bidir_data_oe (serial_bidir_data_oe),
    .nvm_rd               (nvm_rd),
    .nvm_wr               (nvm_wr),
    .nvm_addr             (nvm_addr)
);

// File: sim/tsp_host.sv
`timescale 1ns/1ps
module tsp_host (
    input wire logic mclk,
    input wire logic dev_out,
    input wire logic dev_oe,
    output logic     cs_n,
    output logic     sclk,
    output logic     line
);
    logic drv = 1'b0;
    logic d = 1'b0;
    logic last = 1'b0;
    // idle: chip select high, clock high
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
    end
    // wired line; nobody driving gives a changing level
    assign line = dev_oe ? dev_out : drv ? d : ~last;
    always_ff @(posedge mclk) last <= line;
    // one framed transfer of nb clocks, read data gathered on rising edges
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nb, output logic [15:0] rd);
        logic [31:0] f;
        f = {cmd, 8'h00, wd};
        rd = 16'h0000;
        @(posedge mclk) cs_n <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < nb; i++)
        begin
            sclk <= 1'b0;
            drv <= cmd[7] || i < 16;
            d <= f[31 - i];
            repeat (8) @(posedge mclk);
            sclk <= 1'b1;
            drv <= cmd[7] || i < 15;
            if (i >= 16)
                rd = {rd[14:0], line};
            repeat (8) @(posedge mclk);
        end
        cs_n <= 1'b1;
        drv <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule
